/* File: hw/b2sr_pkg.sv */
// Purpose: shared constants and types for the burst-of-two split-port SRAM
// Assumes: one system clock; link clock edges arrive as one-cycle rise pulses
// Notes: each location holds two 18-bit words, stored as four 9-bit lanes
package b2sr_pkg;
   localparam int ADDR_W = 18;
   localparam int WORD_W = 18;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int PAIR_W = 2 * WORD_W;
   localparam int MEM_DEPTH = 262144;
   localparam int FIFO_DEPTH = 8;
   localparam int CMT_W = ADDR_W + PAIR_W + LANES;
   localparam logic [1:0] BYTE_SEL_IDLE = 2'h3;
   localparam logic [WORD_W-1:0] WORD_ZERO = 18'h00000;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_LOW = 2'b01,
      RD_HIGH = 2'b10
   } b2sr_rd_state_t;

   // Byte selects are active low; a lane is written when its select is low
   function automatic logic [1:0] b2sr_lane_mask(input logic [1:0] selN);
      return ~selN;
   endfunction
endpackage

/* File: hw/b2sr_stream_if.sv */
// Purpose: valid/ready carrier for write commits between the core and its FIFO
// Assumes: single clock domain
// Notes: source drives valid and data, sink drives ready
`timescale 1ns/1ps
interface b2sr_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

/* File: hw/b2sr_fifo.sv */
// Purpose: small synchronous FIFO holding write commits before the array
// Assumes: DEPTH is a power of two
// Notes: honest full and empty; a stalled drain fills it and stalls the filler
`timescale 1ns/1ps
module b2sr_fifo
   import b2sr_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   b2sr_stream_if.sink fillPort,
   b2sr_stream_if.source drainPort
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW:0] wrPtrReg;
   logic [PW:0] rdPtrReg;
   wire full = (wrPtrReg[PW] != rdPtrReg[PW]) && (wrPtrReg[PW-1:0] == rdPtrReg[PW-1:0]);
   wire empty = (wrPtrReg == rdPtrReg);
   wire doPush = fillPort.valid && !full;
   wire doPop = drainPort.ready && !empty;

   assign fillPort.ready = !full;
   assign drainPort.valid = !empty;
   assign drainPort.data = store[rdPtrReg[PW-1:0]];

   always_ff @(posedge sys_clk) begin
      if (doPush) begin
         store[wrPtrReg[PW-1:0]] <= fillPort.data;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtrReg <= '0;
         rdPtrReg <= '0;
      end else begin
         if (doPush) begin
            wrPtrReg <= wrPtrReg + 1'b1;
         end
         if (doPop) begin
            rdPtrReg <= rdPtrReg + 1'b1;
         end
      end
   end

   fifo_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wrPtrReg - rdPtrReg) <= (PW+1)'(DEPTH))
      else $error("FIFO occupancy exceeds depth");
   fifo_full_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) full);
endmodule

/* File: hw/b2sr_top.sv */
// Purpose: split-port burst-of-two SRAM core with shared address bus
// Assumes: clock pair edges arrive as one-cycle pulses synchronous to sys_clk
// Notes: output clock edges must trail the K rise by a few sys_clk cycles
// Operation
// - Every read or write starts only on a positive input clock rise.
// - Write data captured on rises of both input clocks.
// - Read data launched on output clock rises, input clocks in single mode.
// - Port selects and byte selects registered on input clock rises.
// - Two 256K by 18 arrays; every access is a two-word burst.
// - Read starts with read select low; address latched on that rise.
// - Lower read word driven after next K rise, on output clock rise.
// - Higher read word driven on the following negative output clock rise.
// - With no further read, outputs float after next positive output rise.
// - Write starts with write select low on a positive input rise.
// - First write word loaded on starting rise, per enabled byte.
// - Negative input rise latches write address and second word.
// - Both words then committed together to the array at that address.
// - Deselected write port finishes pending write, then ignores inputs.
// - Shared address: read address on K rise, write on negative rise.
// - Low byte select gates bits 8:0, high gates 17:9; others unchanged.
// - Deselected read port completes pending burst, then floats outputs.
// - Both output clocks high at power-up selects fixed single clock mode.
// - Colliding read returns the most recent data, waiting until prior writes reach the array.
`timescale 1ns/1ps
module b2sr_top
   import b2sr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic kRise,
   input wire logic kbRise,
   input wire logic cRise,
   input wire logic cbRise,
   input wire logic cLevel,
   input wire logic cbLevel,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic upper_addr_tie_low_a,
   input wire logic upper_addr_tie_low_b,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic [1:0] byte_write_select_n,
   input wire logic [WORD_W-1:0] dataIn,
   output logic [WORD_W-1:0] dataOut,
   output logic dataOutEn
);
   // Strap capture at the first cycle after reset release
   logic strapDoneReg;
   logic singleClkReg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strapDoneReg <= 1'b0;
         singleClkReg <= 1'b0;
      end else if (!strapDoneReg) begin
         strapDoneReg <= 1'b1;
         singleClkReg <= cLevel && cbLevel;
      end
   end

   wire outRise = singleClkReg ? kRise : cRise;
   wire outRiseB = singleClkReg ? kbRise : cbRise;

   // Write port capture
   logic wrActiveReg;
   logic [WORD_W-1:0] wrLowReg;
   logic [1:0] wrLowMaskReg;
   logic cmtValidReg;
   logic [CMT_W-1:0] cmtReg;
   wire wrStart = kRise && !write_port_select_n;
   wire wrSecond = kbRise && wrActiveReg;
   wire [1:0] laneSelMask = b2sr_lane_mask(byte_write_select_n);

   b2sr_stream_if #(.W(CMT_W)) fillIf ();
   b2sr_stream_if #(.W(CMT_W)) drainIf ();

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrActiveReg <= 1'b0;
         wrLowReg <= WORD_ZERO;
         wrLowMaskReg <= 2'h0;
      end else if (kRise) begin
         wrActiveReg <= wrStart;
         if (wrStart) begin
            wrLowReg <= dataIn;
            wrLowMaskReg <= laneSelMask;
         end
      end else if (kbRise) begin
         wrActiveReg <= 1'b0;
      end
   end

   // Commit word: address, upper word, lower word, lane enables
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmtValidReg <= 1'b0;
         cmtReg <= '0;
      end else if (wrSecond) begin
         cmtValidReg <= 1'b1;
         cmtReg <= {addr, dataIn, wrLowReg, laneSelMask, wrLowMaskReg};
      end else if (fillIf.ready) begin
         cmtValidReg <= 1'b0;
      end
   end

   assign fillIf.valid = cmtValidReg;
   assign fillIf.data = cmtReg;

   b2sr_fifo #(.WIDTH(CMT_W), .DEPTH(FIFO_DEPTH)) cmtFifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .fillPort(fillIf),
      .drainPort(drainIf)
   );

   // Read port capture and lookup pipeline
   // A read is looked up only after the next K rise, so a write begun at its own
   // K rise can still reach the array first; the cost is a longer read latency
   logic rdCapReg;
   logic [ADDR_W-1:0] rdCapAddrReg;
   logic lkPendReg;
   logic [ADDR_W-1:0] lkAddrReg;
   logic rdDoneReg;
   // Lookup waits until all earlier writes reach the array, so it sees newest data
   wire memRd = lkPendReg && !drainIf.valid && !cmtValidReg;
   // The K rise cycle is kept free of array drains; the FIFO absorbs the stall
   assign drainIf.ready = !kRise;
   wire memWr = drainIf.valid && drainIf.ready;
   wire [ADDR_W-1:0] memWrAddr = drainIf.data[CMT_W-1 -: ADDR_W];
   wire [PAIR_W-1:0] memWrData = drainIf.data[LANES +: PAIR_W];
   wire [LANES-1:0] memWrLanes = drainIf.data[LANES-1:0];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdCapReg <= 1'b0;
         rdCapAddrReg <= '0;
         lkPendReg <= 1'b0;
         lkAddrReg <= '0;
         rdDoneReg <= 1'b0;
      end else begin
         rdDoneReg <= memRd;
         if (kRise) begin
            rdCapReg <= !read_port_select_n;
            rdCapAddrReg <= addr;
            lkPendReg <= rdCapReg;
            lkAddrReg <= rdCapAddrReg;
         end else if (memRd) begin
            lkPendReg <= 1'b0;
         end
      end
   end

   // Array: four 9-bit lanes, each written only where its select was low
   logic [LANE_W-1:0] rdLaneReg [LANES];
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : laneGen
         logic [LANE_W-1:0] laneMem [MEM_DEPTH];
         always_ff @(posedge sys_clk) begin
            if (memWr && memWrLanes[g]) begin
               laneMem[memWrAddr] <= memWrData[g*LANE_W +: LANE_W];
            end
            if (memRd) begin
               rdLaneReg[g] <= laneMem[lkAddrReg];
            end
         end
      end
   endgenerate

   wire [PAIR_W-1:0] rdPair = {rdLaneReg[3], rdLaneReg[2], rdLaneReg[1], rdLaneReg[0]};

   // Output burst sequencer
   // A positive output rise outranks a negative one arriving in the same cycle
   b2sr_rd_state_t rdStateReg;
   logic pairValidReg;
   logic [PAIR_W-1:0] pairReg;
   logic [WORD_W-1:0] upperReg;
   wire launchLow = outRise && pairValidReg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pairValidReg <= 1'b0;
         pairReg <= '0;
      end else if (rdDoneReg) begin
         pairValidReg <= 1'b1;
         pairReg <= rdPair;
      end else if (launchLow) begin
         pairValidReg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdStateReg <= RD_IDLE;
         dataOut <= WORD_ZERO;
         dataOutEn <= 1'b0;
         upperReg <= WORD_ZERO;
      end else if (outRise) begin
         if (pairValidReg) begin
            rdStateReg <= RD_LOW;
            dataOut <= pairReg[WORD_W-1:0];
            upperReg <= pairReg[PAIR_W-1:WORD_W];
            dataOutEn <= 1'b1;
         end else begin
            rdStateReg <= RD_IDLE;
            dataOutEn <= 1'b0;
         end
      end else if (outRiseB) begin
         case (rdStateReg)
            RD_LOW: begin
               rdStateReg <= RD_HIGH;
               dataOut <= upperReg;
            end
            RD_HIGH: rdStateReg <= RD_HIGH;
            RD_IDLE: rdStateReg <= RD_IDLE;
            default: rdStateReg <= RD_IDLE;
         endcase
      end
   end

   // Checks
   start_on_k_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !kRise |=> $stable(rdCapReg) && $stable(lkAddrReg))
      else $error("Read capture moved without a K rise");
   rd_addr_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      kRise && !read_port_select_n |=> rdCapReg && rdCapAddrReg == $past(addr))
      else $error("Read address not latched on K rise");
   wr_first_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wrStart |=> wrActiveReg && wrLowReg == $past(dataIn)
      && wrLowMaskReg == ~$past(byte_write_select_n))
      else $error("First write word or mask not captured");
   wr_second_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wrSecond |=> cmtValidReg && cmtReg[CMT_W-1 -: ADDR_W] == $past(addr)
      && cmtReg[LANES+WORD_W +: WORD_W] == $past(dataIn))
      else $error("Write address or second word not latched");
   wr_deselect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      kbRise && !wrActiveReg && !cmtValidReg |=> !cmtValidReg)
      else $error("Deselected write port produced a commit");
   rd_newest_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      memRd |-> !memWr && !cmtValidReg)
      else $error("Read lookup overtook a pending write");
   rd_low_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      launchLow |=> dataOutEn && dataOut == $past(pairReg[WORD_W-1:0])
      && rdStateReg == RD_LOW)
      else $error("Lower read word not launched");
   rd_high_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      outRiseB && !outRise && rdStateReg == RD_LOW |=> dataOutEn
      && dataOut == $past(upperReg))
      else $error("Higher read word not launched");
   rd_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      outRise && !pairValidReg |=> !dataOutEn && $stable(dataOut))
      else $error("Outputs not floated after idle output rise");
   mode_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      strapDoneReg |=> $stable(singleClkReg))
      else $error("Clock mode changed during operation");

   out_on_clk_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !outRise && !outRiseB |=> $stable(dataOut) && $stable(dataOutEn))
      else $error("Read outputs moved without an output clock rise");
   wr_sel_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !kRise && !kbRise |=> $stable(wrActiveReg) && $stable(wrLowReg))
      else $error("Write capture moved without an input clock rise");
   rd_burst_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      outRiseB && !outRise && rdStateReg == RD_LOW |=> rdStateReg == RD_HIGH)
      else $error("Read burst did not reach its second word");
   rd_no_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      kRise && read_port_select_n |=> !rdCapReg)
      else $error("Read began without its port select");
   pair_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pairValidReg && !outRise && !rdDoneReg |=> pairValidReg && $stable(pairReg))
      else $error("Read pair lost before its output rise");
   wr_no_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      kRise && write_port_select_n |=> !wrActiveReg)
      else $error("Write began without its port select");
   cmt_queue_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cmtValidReg && fillIf.ready |=> drainIf.valid)
      else $error("Write commit did not reach the queue");
   wr_finish_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      kbRise && wrActiveReg |=> cmtValidReg)
      else $error("Started write was not finished");
   rd_addr_pipe_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      kRise |=> lkAddrReg == $past(rdCapAddrReg))
      else $error("Lookup address not taken from the K rise capture");
   wr_lane_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wrSecond |=> cmtReg[LANES-1:0] == {~$past(byte_write_select_n), $past(wrLowMaskReg)})
      else $error("Byte write selects not carried with the write");
   rd_en_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !launchLow |=> !$rose(dataOutEn))
      else $error("Read outputs enabled without a pending burst");
   strap_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !strapDoneReg |-> ##2 strapDoneReg)
      else $error("Clock mode strap not taken after reset");

   b2b_read_cov: cover property (@(posedge sys_clk) disable iff (!rst_n)
      launchLow ##[1:40] launchLow);
   part_write_cov: cover property (@(posedge sys_clk) disable iff (!rst_n)
      memWr && memWrLanes != 4'hf && memWrLanes != 4'h0);
   single_mode_cov: cover property (@(posedge sys_clk) disable iff (!rst_n)
      singleClkReg && launchLow);
   rw_same_k_cov: cover property (@(posedge sys_clk) disable iff (!rst_n)
      kRise && !read_port_select_n && !write_port_select_n);
endmodule

/* File: sim/b2sr_ctrl_model.sv */
// Purpose: controller side for the burst SRAM bench, makes the clock pair pulses
// Assumes: K period of 12 sys_clk cycles, one-cycle rise pulses
// Notes: C rises trail K by 8 cycles to cover the read lookup latency
`timescale 1ns/1ps
module b2sr_ctrl_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic singleMode,
   output logic kRise,
   output logic kbRise,
   output logic cRise,
   output logic cbRise,
   output logic cLevel,
   output logic cbLevel,
   output logic kSoon,
   output logic kbSoon
);
   logic [3:0] phaseReg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) phaseReg <= 4'h9;
      else phaseReg <= (phaseReg == 4'hb) ? 4'h0 : phaseReg + 4'h1;
   end
   // First K rise lands at the fourth edge after release, after the strap is taken
   assign kRise = (phaseReg == 4'h0);
   assign kbRise = (phaseReg == 4'h6);
   assign kSoon = (phaseReg == 4'hb);
   assign kbSoon = (phaseReg == 4'h5);
   // Both output clocks parked high select single mode; only changed in reset
   assign cLevel = singleMode;
   assign cbLevel = singleMode;
   assign cRise = !singleMode && (phaseReg == 4'h8);
   assign cbRise = !singleMode && (phaseReg == 4'ha);
endmodule

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the split-port burst SRAM core
// Assumes: controller model makes the clock pair pulses
// Notes: words are sampled one edge after their output clock pulse
`timescale 1ns/1ps
module tb_top
   import b2sr_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic singleMode = 1'b0;
   logic rdN = 1'b1;
   logic wrN = 1'b1;
   logic [1:0] bwN = BYTE_SEL_IDLE;
   logic [ADDR_W-1:0] addr = '0;
   logic [WORD_W-1:0] dataIn = WORD_ZERO;
   logic [WORD_W-1:0] dataOut;
   logic dataOutEn, kRise, kbRise, cRise, cbRise, cLevel, cbLevel, kSoon, kbSoon;
   int n_errors = 0;
   int tests_run = 0;

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   b2sr_ctrl_model ctrl_u (.sys_clk(sys_clk), .rst_n(rst_n), .singleMode(singleMode),
      .kRise(kRise), .kbRise(kbRise), .cRise(cRise), .cbRise(cbRise), .cLevel(cLevel),
      .cbLevel(cbLevel), .kSoon(kSoon), .kbSoon(kbSoon));
   b2sr_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .kRise(kRise), .kbRise(kbRise),
      .cRise(cRise), .cbRise(cbRise), .cLevel(cLevel), .cbLevel(cbLevel), .addr(addr),
      .upper_addr_tie_low_a(1'b0), .upper_addr_tie_low_b(1'b0),
      .read_port_select_n(rdN), .write_port_select_n(wrN), .byte_write_select_n(bwN),
      .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn));

   task automatic test_done();
      $display("checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // 0 next edge is K, 1 next edge is K-bar, 2 output rise, 3 output rise B, 4 enabled
   task automatic wait_ev(input int which);
      for (int i = 0; i < 60; i++) begin
         @(posedge sys_clk);
         if ((which == 0 && kSoon) || (which == 1 && kbSoon)
             || (which == 2 && (singleMode ? kRise : cRise))
             || (which == 3 && (singleMode ? kbRise : cbRise))
             || (which == 4 && dataOutEn === 1'b1)) return;
      end
      n_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      test_done();
   endtask

   // One K period; the address bus carries the read address at K, write address at K-bar
   task automatic op(input logic r, input logic w, input logic [ADDR_W-1:0] ra,
                     input logic [ADDR_W-1:0] wa, input logic [WORD_W-1:0] d0,
                     input logic [WORD_W-1:0] d1, input logic [1:0] b0, input logic [1:0] b1);
      wait_ev(0);
      rdN <= r;
      wrN <= w;
      addr <= ra;
      dataIn <= d0;
      bwN <= b0;
      @(posedge sys_clk);
      rdN <= 1'b1;
      wrN <= 1'b1;
      addr <= ~ra;
      dataIn <= ~d0;
      wait_ev(1);
      addr <= wa;
      dataIn <= d1;
      bwN <= b1;
      @(posedge sys_clk);
      addr <= ~wa;
      dataIn <= ~d1;
      bwN <= ~b1;
   endtask

   task automatic burst(input bit first, input logic [WORD_W-1:0] lo, input logic [WORD_W-1:0] hi);
      wait_ev(first ? 4 : 2);
      if (!first) @(posedge sys_clk);
      #1;
      check(WORD_W'(dataOutEn), 18'h00001);
      check(dataOut, lo);
      wait_ev(3);
      @(posedge sys_clk);
      #1;
      check(dataOut, hi);
      check(WORD_W'(dataOutEn), 18'h00001);
   endtask

   task automatic idle_check();
      wait_ev(2);
      @(posedge sys_clk);
      #1;
      check(WORD_W'(dataOutEn), WORD_ZERO);
   endtask

   function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old,
                                               input logic [WORD_W-1:0] nw, input logic [1:0] bN);
      merge = old;
      if (!bN[0]) merge[8:0] = nw[8:0];
      if (!bN[1]) merge[17:9] = nw[17:9];
   endfunction

   initial begin
      logic [WORD_W-1:0] lo;
      logic [WORD_W-1:0] hi;
      lo = 18'h0a5c3;
      hi = 18'h35a3c;
      repeat (10) @(posedge sys_clk);
      #1;
      check(dataOut, WORD_ZERO);
      check(WORD_W'(dataOutEn), WORD_ZERO);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      op(1'b1, 1'b0, 18'h0, 18'h00011, lo, hi, 2'h0, 2'h0);
      op(1'b0, 1'b0, 18'h00011, 18'h00022, 18'h12345, 18'h2abcd, 2'h0, 2'h0);
      op(1'b0, 1'b1, 18'h00022, 18'h0, 18'h0, 18'h0, 2'h3, 2'h3);
      burst(1'b1, lo, hi);
      burst(1'b0, 18'h12345, 18'h2abcd);
      idle_check();
      // Every lane code on both words, read back in the next K period
      for (int b = 0; b < 4; b++) begin
         op(1'b1, 1'b0, 18'h0, 18'h00011, ~lo, ~hi, 2'(b), ~2'(b));
         lo = merge(lo, ~lo, 2'(b));
         hi = merge(hi, ~hi, ~2'(b));
         op(1'b0, 1'b1, 18'h00011, 18'h0, 18'h0, 18'h0, 2'h3, 2'h3);
         burst(1'b1, lo, hi);
         idle_check();
      end
      op(1'b1, 1'b1, 18'h0, 18'h00011, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
      op(1'b0, 1'b1, 18'h00011, 18'h0, 18'h0, 18'h0, 2'h3, 2'h3);
      burst(1'b1, lo, hi);
      idle_check();
      @(posedge sys_clk);
      rst_n <= 1'b0;
      singleMode <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      op(1'b0, 1'b1, 18'h00022, 18'h0, 18'h0, 18'h0, 2'h3, 2'h3);
      burst(1'b1, 18'h12345, 18'h2abcd);
      idle_check();
      test_done();
   end
endmodule
